// ### mccs_mac_model.sv
// MAC and station manager model driving transmit enable and MDC.
// Assumes the bench requests frames and management clocking.
`timescale 1ns/1ps
`default_nettype none
module mccs_mac_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Requests from the bench
	input wire logic tx_req,
	input wire logic mdc_on,
	// Toward the device
	output logic tx_en,
	output logic mdc
);
	logic [1:0] div_ff; // Management clock divider, period four cycles
	// MDC is ours to make and parks low between transfers
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tx_en <= 1'b0;
			mdc <= 1'b0;
			div_ff <= 2'h0;
		end
		else
		begin
			tx_en <= tx_req;
			mdc <= mdc_on && div_ff[1];
			div_ff <= mdc_on ? div_ff + 2'h1 : 2'h0;
		end
	end
endmodule
`default_nettype wire

// ### mccs_pkg.sv
// Constants shared by the MII carrier and collision status block.
// Assumes a single 20 MHz system clock.
package mccs_pkg;
	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50; // 20 MHz
	localparam int SQE_DELAY_NS = 1000; // Quiet gap after transmit ends
	localparam int SQE_WIDTH_NS = 1000; // Length of heartbeat pulse
	// Least times round up to whole cycles
	localparam int SQE_DELAY_CYC = (SQE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SQE_WIDTH_CYC = (SQE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SQE_CNT_W = 8;

	// ---------------------------------------------------------------
	// Register map (word index, byte address is index times four)
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] IDX_STAT = 8'h11;
	localparam logic [ADDR_W-1:0] IDX_CFG = 8'h12; // Register 18
	// Control fields
	localparam int CTRL_SPEED_100 = 0;
	localparam int CTRL_FULL_DUPLEX = 1;
	localparam int CTRL_REPEATER = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// Configuration fields
	localparam int CFG_HB_SUPPRESS = 2; // Bit 18.2
	localparam logic CFG_RESET = 1'b0;
	// Status fields
	localparam int STAT_COL = 0;
	localparam int STAT_CRS = 1;
	localparam int STAT_RX_ACT = 2;
	localparam int STAT_TX_ACT = 3;
	localparam int STAT_HB = 4;

	// ---------------------------------------------------------------
	// Receive code stream
	// ---------------------------------------------------------------
	localparam int SYMBOL_BITS = 10;

	// Heartbeat sequencer, Gray from IDLE to WAIT to PULSE
	typedef enum logic [1:0] {
		MCCS_HB_IDLE = 2'h0,
		MCCS_HB_WAIT = 2'h1,
		MCCS_HB_PULSE = 2'h3
	} mccs_hb_t;
endpackage

// ### mccs_sym_act.sv
// Receive activity detector for the 100 Mb/s code stream.
// Assumes code bits arrive on the system clock with a valid strobe.
`timescale 1ns/1ps
`default_nettype none
module mccs_sym_act
	import mccs_pkg::*;
#(
	parameter int WIN = SYMBOL_BITS
)(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Code stream
	input wire logic code_bit,
	input wire logic code_valid,
	// Result
	output logic active
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [WIN-1:0] win; // Last WIN code bits
		logic act; // Activity flag
	} mccs_sa_t;

	mccs_sa_t s_ff;
	mccs_sa_t nxt_s;

	// Two zeros with at least one bit between them
	function automatic logic split_zeros(input logic [WIN-1:0] w);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < WIN; i++)
		begin
			for (int j = i + 2; j < WIN; j++)
			begin
				if (!w[i] && !w[j])
				begin
					hit = 1'b1;
				end
			end
		end
		return hit;
	endfunction

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	// Idle line is all ones, so activity drops once zeros leave
	always_comb
	begin
		nxt_s = s_ff;
		if (code_valid)
		begin
			nxt_s.win = {s_ff.win[WIN-2:0], code_bit};
			nxt_s.act = split_zeros({s_ff.win[WIN-2:0], code_bit});
		end
	end

	// Register
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_ff <= '{win: '1, act: 1'b0};
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	assign active = s_ff.act;
endmodule
`default_nettype wire

// ### mccs_top.sv
// Carrier sense, collision and speed status toward the MAC.
// Assumes pins and MAC transmit enable are asynchronous to clk;
// the 100 Mb/s code stream comes from same-clock receive logic.
`timescale 1ns/1ps
`default_nettype none
module mccs_top
	import mccs_pkg::*;
#(
	parameter int HB_DELAY = SQE_DELAY_CYC,
	parameter int HB_WIDTH = SQE_WIDTH_CYC
)(
	// Clock and synchronous reset
	input wire logic clk,
	input wire logic reset,
	// Device pins
	input wire logic hardware_reset_low_in,
	input wire logic mdc,
	// MAC side, asynchronous
	input wire logic tx_en,
	// Medium receive side
	input wire logic rx_unsquelched,
	input wire logic rx_code_bit,
	input wire logic rx_code_valid,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Status toward MAC
	output logic col,
	output logic crs,
	output logic speed_indicator_out,
	// Management timing
	output logic mgmt_sample_strobe
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic hwr_s1; // Reset pin, first stage
		logic hwr_s2; // Reset pin, second stage
		logic tx_s1; // Transmit enable sync
		logic tx_s2;
		logic tx_d; // Edge detect copy
		logic rx_s1; // Unsquelched line sync
		logic rx_s2;
		logic mdc_s1; // Management clock sync
		logic mdc_s2;
		logic mdc_d;
		logic [2:0] ctrl; // Speed, duplex, repeater
		logic hb_sup; // Heartbeat suppress
		mccs_hb_t hb; // Heartbeat sequencer
		logic [SQE_CNT_W-1:0] hb_cnt;
		logic col; // Output copies
		logic crs;
		logic spd;
		logic mgmt;
		logic [DATA_W-1:0] rdata;
	} mccs_st_t;

	localparam mccs_st_t ST_RESET = '{
		hwr_s1: 1'b0,
		hwr_s2: 1'b0,
		tx_s1: 1'b0,
		tx_s2: 1'b0,
		tx_d: 1'b0,
		rx_s1: 1'b0,
		rx_s2: 1'b0,
		mdc_s1: 1'b0,
		mdc_s2: 1'b0,
		mdc_d: 1'b0,
		ctrl: CTRL_RESET,
		hb_sup: CFG_RESET,
		hb: MCCS_HB_IDLE,
		hb_cnt: '0,
		col: 1'b0,
		crs: 1'b0,
		spd: 1'b0,
		mgmt: 1'b0,
		rdata: '0
	};

	// Counter targets; the counter is eight bits, so parameters stay below 256
	localparam logic [SQE_CNT_W-1:0] HB_DELAY_C = SQE_CNT_W'(HB_DELAY);
	localparam logic [SQE_CNT_W-1:0] HB_WIDTH_C = SQE_CNT_W'(HB_WIDTH);

	mccs_st_t s_ff;
	mccs_st_t nxt_s;

	// Combinational helpers
	logic sym_act; // 100M activity from detector
	logic core_rst; // Reset of the code activity detector, system reset or synced pin reset
	logic speed_100;
	logic full_dup;
	logic repeater;
	logic rx_act;
	logic tx_act;
	logic hb_on;

	// Word index of a byte address
	// The low two address bits are dropped, so any byte lane hits its word
	function automatic logic [ADDR_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
		return {2'h0, a[ADDR_W-1:2]};
	endfunction

	// ---------------------------------------------------------------
	// Receive code activity
	// ---------------------------------------------------------------
	// Held in reset with the core so a stale window cannot leak out
	// The detector sits on the same clock, so no sync is needed here
	assign core_rst = reset || !s_ff.hwr_s2;

	mccs_sym_act #(
		.WIN(SYMBOL_BITS)
	) u_sym_act (
		.clk(clk),
		.reset(core_rst),
		.code_bit(rx_code_bit),
		.code_valid(rx_code_valid),
		.active(sym_act)
	);

	// ---------------------------------------------------------------
	// Mode decode and activity
	// ---------------------------------------------------------------
	always_comb
	begin
		speed_100 = s_ff.ctrl[CTRL_SPEED_100];
		full_dup = s_ff.ctrl[CTRL_FULL_DUPLEX];
		repeater = s_ff.ctrl[CTRL_REPEATER];
		tx_act = s_ff.tx_s2;
		// Speed picks the activity source
		// Both sources are kept live so a speed change needs no flush
		if (speed_100)
		begin
			rx_act = sym_act;
		end
		else
		begin
			rx_act = s_ff.rx_s2;
		end
		// Heartbeat only reaches the pin when not suppressed
		hb_on = (s_ff.hb == MCCS_HB_PULSE) && !s_ff.hb_sup;
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_s = s_ff;

		// Pin synchronisers, never held by the pin reset
		// They clear only on reset, so the core wakes up in pin reset
		nxt_s.hwr_s1 = hardware_reset_low_in;
		nxt_s.hwr_s2 = s_ff.hwr_s1;
		nxt_s.tx_s1 = tx_en;
		nxt_s.tx_s2 = s_ff.tx_s1;
		nxt_s.tx_d = s_ff.tx_s2;
		nxt_s.rx_s1 = rx_unsquelched;
		nxt_s.rx_s2 = s_ff.rx_s1;
		nxt_s.mdc_s1 = mdc;
		nxt_s.mdc_s2 = s_ff.mdc_s1;
		nxt_s.mdc_d = s_ff.mdc_s2;

		// Management data sampled on rising management clock
		// Strobe lags the pin by three edges, small beside any legal period
		nxt_s.mgmt = s_ff.mdc_s2 && !s_ff.mdc_d;

		// Register writes
		if (reg_wr)
		begin
			case (word_idx(reg_addr))
				IDX_CTRL:
				begin
					nxt_s.ctrl = reg_wdata[2:0];
				end
				IDX_CFG:
				begin
					nxt_s.hb_sup = reg_wdata[CFG_HB_SUPPRESS];
				end
				default:
				begin
					// Unmapped or read-only: ignored
				end
			endcase
		end

		// Register reads, data valid one cycle only
		// Cleared every cycle so the port reads zero between reads
		nxt_s.rdata = '0;
		if (reg_rd)
		begin
			case (word_idx(reg_addr))
				IDX_CTRL:
				begin
					nxt_s.rdata[2:0] = s_ff.ctrl;
				end
				IDX_STAT:
				begin
					// Live snapshot; nothing here clears on read
					nxt_s.rdata[STAT_COL] = s_ff.col;
					nxt_s.rdata[STAT_CRS] = s_ff.crs;
					nxt_s.rdata[STAT_RX_ACT] = rx_act;
					nxt_s.rdata[STAT_TX_ACT] = tx_act;
					nxt_s.rdata[STAT_HB] = s_ff.hb == MCCS_HB_PULSE;
				end
				IDX_CFG:
				begin
					nxt_s.rdata[CFG_HB_SUPPRESS] = s_ff.hb_sup;
				end
				default:
				begin
					// Unmapped reads return zero
				end
			endcase
		end

		// Heartbeat sequencer: after each 10M half-duplex frame
		// One counter serves both the gap and the pulse, saving flops
		case (s_ff.hb)
			MCCS_HB_IDLE:
			begin
				nxt_s.hb_cnt = '0;
				// Falling transmit enable starts the test
				if (s_ff.tx_d && !tx_act && !speed_100 && !full_dup)
				begin
					nxt_s.hb = MCCS_HB_WAIT;
				end
			end
			MCCS_HB_WAIT:
			begin
				nxt_s.hb_cnt = s_ff.hb_cnt + 1'b1;
				// New frame cancels a pending test
				if (tx_act)
				begin
					nxt_s.hb = MCCS_HB_IDLE;
				end
				else if (s_ff.hb_cnt == HB_DELAY_C - 1'b1)
				begin
					nxt_s.hb = MCCS_HB_PULSE;
					nxt_s.hb_cnt = '0;
				end
			end
			MCCS_HB_PULSE:
			begin
				nxt_s.hb_cnt = s_ff.hb_cnt + 1'b1;
				if (s_ff.hb_cnt == HB_WIDTH_C - 1'b1)
				begin
					nxt_s.hb = MCCS_HB_IDLE;
				end
			end
			default:
			begin
				nxt_s.hb = MCCS_HB_IDLE;
			end
		endcase

		// Collision: pin is free-running level, MAC syncs it
		// Full duplex is tested first so a heartbeat can never leak out
		if (full_dup)
		begin
			nxt_s.col = 1'b0;
		end
		else
		begin
			nxt_s.col = (rx_act && tx_act) || hb_on;
		end

		// Carrier sense: own transmit counts only in half duplex with repeater mode off
		if (full_dup || repeater)
		begin
			nxt_s.crs = rx_act;
		end
		else
		begin
			nxt_s.crs = rx_act || tx_act;
		end

		// Speed indicator follows the selected mode
		// Low while the 10M path is selected, high for 100M
		nxt_s.spd = speed_100;

		// Pin reset holds all but the synchronisers
		// Kept last so the pin beats a register write in the same cycle
		if (!s_ff.hwr_s2)
		begin
			nxt_s.ctrl = ST_RESET.ctrl;
			nxt_s.hb_sup = ST_RESET.hb_sup;
			nxt_s.hb = ST_RESET.hb;
			nxt_s.hb_cnt = ST_RESET.hb_cnt;
			nxt_s.col = 1'b0;
			nxt_s.crs = 1'b0;
			nxt_s.spd = 1'b0;
			nxt_s.mgmt = 1'b0;
			nxt_s.rdata = '0;
		end
	end

	// ---------------------------------------------------------------
	// Register
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_ff <= ST_RESET;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	// ---------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ---------------------------------------------------------------
	// No decode reaches a pin, so the MAC never sees a glitch
	assign col = s_ff.col;
	assign crs = s_ff.crs;
	assign speed_indicator_out = s_ff.spd;
	assign mgmt_sample_strobe = s_ff.mgmt;
	assign reg_rdata = s_ff.rdata;
endmodule
`default_nettype wire

// ### mccs_top_sva.sv
// Checker for the status outputs of mccs_top.
// Assumes it is bound to mccs_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mccs_top_sva
	import mccs_pkg::*;
#(
	parameter int HB_DELAY = SQE_DELAY_CYC,
	parameter int HB_WIDTH = SQE_WIDTH_CYC
)(
	// Clock, reset and pins
	input wire logic clk,
	input wire logic reset,
	input wire logic hardware_reset_low_in,
	input wire logic mdc,
	input wire logic tx_en,
	input wire logic rx_unsquelched,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// Status outputs
	input wire logic col,
	input wire logic crs,
	input wire logic speed_indicator_out,
	input wire logic mgmt_sample_strobe
);
	localparam int HB_MAX = HB_DELAY + 8; // Slack for sync and sequencer
	logic [2:0] up_ff; // Settling count, held off by resets and mode writes
	logic [2:0] ctrl_ff; // Mirror of the mode register
	logic sup_ff; // Mirror of the suppress bit
	logic wr_ctrl;
	logic wr_cfg;
	logic quiet; // Mode stable long enough for outputs to follow
	assign wr_ctrl = reg_wr && reg_addr == 8'h40;
	assign wr_cfg = reg_wr && reg_addr == 8'h48;
	assign quiet = up_ff == 3'h7;
	// Mirror clears early on the pin, which is safe: quiet waits anyway
	always_ff @(posedge clk)
	begin
		if (reset || !hardware_reset_low_in)
		begin
			up_ff <= 3'h0;
			ctrl_ff <= 3'h0;
			sup_ff <= 1'b0;
		end
		else
		begin
			up_ff <= (wr_ctrl || wr_cfg) ? 3'h4 : up_ff + {2'h0, !quiet};
			ctrl_ff <= wr_ctrl ? reg_wdata[2:0] : ctrl_ff;
			sup_ff <= wr_cfg ? reg_wdata[2] : sup_ff;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Heartbeat: end of transmit, then a collision pulse
	sequence tx_end_s;
		quiet && ctrl_ff == 3'h0 && !sup_ff && !rx_unsquelched && $fell(tx_en);
	endsequence
	sequence hb_seen_s;
		##[2:HB_MAX] col;
	endsequence
	speed_level_a: assert property (quiet |-> speed_indicator_out == ctrl_ff[0])
		else $error("speed output differs from mode");
	pin_reset_a: assert property ((!hardware_reset_low_in)[*4] |->
		!col && !crs && !speed_indicator_out && reg_rdata == 32'h0) else $error("pin reset leak");
	collision_set_a: assert property (quiet && ctrl_ff[1:0] == 2'h0 &&
		$past(rx_unsquelched, 3) && $past(tx_en, 3) |-> col) else $error("collision missed");
	full_duplex_a: assert property (quiet && ctrl_ff[1] |-> !col)
		else $error("collision in full duplex");
	hb_suppress_a: assert property (quiet && sup_ff && !$past(tx_en, 3) |-> !col)
		else $error("collision while heartbeat suppressed");
	hb_pulse_a: assert property (tx_end_s |-> hb_seen_s)
		else $error("heartbeat collision missing");
	crs_half_a: assert property (quiet && ctrl_ff[2:1] == 2'h0 && $past(tx_en, 3) |-> crs)
		else $error("carrier missing on transmit");
	crs_rx_only_a: assert property (quiet && !ctrl_ff[0] && ctrl_ff[2:1] != 2'h0 |->
		crs == $past(rx_unsquelched, 3)) else $error("carrier not from receive only");
	read_once_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	mgmt_strobe_a: assert property (quiet && $rose(mdc) |-> ##[2:3] mgmt_sample_strobe)
		else $error("management strobe missing");
endmodule
bind mccs_top mccs_top_sva #(.HB_DELAY(HB_DELAY), .HB_WIDTH(HB_WIDTH)) u_sva (.clk(clk),
	.reset(reset), .hardware_reset_low_in(hardware_reset_low_in), .mdc(mdc), .tx_en(tx_en),
	.rx_unsquelched(rx_unsquelched), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .col(col), .crs(crs),
	.speed_indicator_out(speed_indicator_out), .mgmt_sample_strobe(mgmt_sample_strobe));
`default_nettype wire

// ### mccs_top_tb.sv
// Self-checking bench for mccs_top with a MAC model.
// Assumes the package, checker and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module mccs_top_tb
	import mccs_pkg::*;
	;
	localparam int HB_W = 3; // Short heartbeat keeps the run brief
	typedef struct packed {logic [2:0] m; logic t; logic r; logic c; logic s;} mccs_row_t;
	logic clk, reset, pin_n, rx_u, code_bit, code_vld, reg_wr, reg_rd, tx_req, mdc_on;
	logic tx_en, mdc, col, crs, spd, strobe;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	int fails = 0;
	int checks = 0;
	int cyc, n;
	mccs_row_t r;
	// Mode, transmit, receive, then expected collision and carrier
	mccs_row_t rows [9] = '{7'h00, 7'h09, 7'h05, 7'h0f, 7'h2d, 7'h28, 7'h48, 7'h5c, 7'h14};
	mccs_top #(.HB_DELAY(3), .HB_WIDTH(HB_W)) u_dut (.clk(clk), .reset(reset),
		.hardware_reset_low_in(pin_n), .mdc(mdc), .tx_en(tx_en), .rx_unsquelched(rx_u),
		.rx_code_bit(code_bit), .rx_code_valid(code_vld), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .col(col), .crs(crs),
		.speed_indicator_out(spd), .mgmt_sample_strobe(strobe));
	mccs_mac_model u_mac (.clk(clk), .reset(reset), .tx_req(tx_req), .mdc_on(mdc_on),
		.tx_en(tx_en), .mdc(mdc));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		tick(1);
		reg_wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		addr <= a;
		reg_rd <= 1'b1;
		tick(1);
		reg_rd <= 1'b0;
		tick(1);
		chk(nm, rdata, e);
	endtask
	task automatic send(input logic [15:0] bits, input int k);
		for (int i = k - 1; i >= 0; i--)
		begin
			code_bit <= bits[i];
			code_vld <= 1'b1;
			tick(1);
		end
		code_vld <= 1'b0;
	endtask
	// One short frame, then count collision cycles after it
	task automatic hb(input logic [31:0] e);
		tx_req <= 1'b1;
		tick(5);
		tx_req <= 1'b0;
		n = 0;
		repeat (30)
		begin
			tick(1);
			n += (col === 1'b1);
		end
		chk("heartbeat cycles", n, e);
	endtask
	task automatic complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		// System clock only; the 25 MHz reference comes from the board
		forever #25 clk = ~clk;
	end
	// Hang guard, ample for about 330 cycles of tests
	initial
	begin
		cyc = 0;
		forever
		begin
			tick(1);
			cyc++;
			if (cyc == 2000)
			begin
				fails++;
				complete_run();
			end
		end
	end
	initial
	begin
		reset = 1'b1;
		pin_n = 1'b1;
		{rx_u, code_bit, code_vld, reg_wr, reg_rd, tx_req, mdc_on} = 7'h00;
		addr = 8'h00;
		wdata = 32'h0;
		tick(20);
		reset <= 1'b0;
		tick(4);
		rd(8'h40, 32'h0, "ctrl reset");
		rd(8'h48, 32'h0, "cfg reset");
		rd(8'h4c, 32'h0, "unmapped");
		// Suppress keeps heartbeat out of the table
		wr(8'h48, 32'h4);
		tick(1);
		foreach (rows[i])
		begin
			r = rows[i];
			wr(8'h40, {29'h0, r.m});
			tx_req <= r.t;
			rx_u <= r.r;
			tick(8);
			chk("col", col, r.c);
			chk("crs", crs, r.s);
			chk("speed", spd, r.m[0]);
		end
		wr(8'h40, 32'h0);
		tx_req <= 1'b1;
		rx_u <= 1'b1;
		tick(8);
		rd(8'h44, 32'hf, "status");
		tx_req <= 1'b0;
		rx_u <= 1'b0;
		tick(30);
		wr(8'h48, 32'h0);
		tick(4);
		hb(HB_W);
		wr(8'h48, 32'h4);
		tick(4);
		hb(32'h0);
		// Adjacent zeros are idle, split zeros are activity
		wr(8'h40, 32'h1);
		tx_req <= 1'b1;
		send(16'h0013, 5);
		tick(3);
		chk("col joined zeros", col, 1'b0);
		send(16'h0002, 3);
		tick(3);
		chk("col split zeros", col, 1'b1);
		send(16'h0fff, 12);
		tick(3);
		chk("col after ones", col, 1'b0);
		tx_req <= 1'b0;
		pin_n <= 1'b0;
		tick(6);
		chk("speed in pin reset", spd, 1'b0);
		pin_n <= 1'b1;
		tick(6);
		rd(8'h40, 32'h0, "ctrl after pin reset");
		n = 0;
		mdc_on <= 1'b1;
		for (int i = 1; i <= 48; i++)
		begin
			tick(1);
			n += (strobe === 1'b1);
			if (i == 40)
				mdc_on <= 1'b0;
		end
		chk("mdc strobes", n, 32'h0a);
		complete_run();
	end
endmodule
`default_nettype wire
